// ===== rtl/cansf_map.vh
`ifndef CANSF_MAP_VH
`define CANSF_MAP_VH
// ==========================================================
// register indices (byte address is four times the index)
`define CANSF_IDX_MODULE_CTRL 10'h100
`define CANSF_IDX_RX_FLAGS 10'h104
`define CANSF_IDX_RX_IRQ_EN 10'h105
`define CANSF_IDX_TX_FLAGS 10'h106
`define CANSF_IDX_TX_CTRL 10'h107
`define CANSF_IDX_RX_ERR_CNT 10'h10e
`define CANSF_IDX_TX_ERR_CNT 10'h10f
// ==========================================================
// rx status flag / rx irq enable bit positions
`define CANSF_BIT_WAKE 7
`define CANSF_BIT_RX_WARN 6
`define CANSF_BIT_TX_WARN 5
`define CANSF_BIT_RX_PASS 4
`define CANSF_BIT_TX_PASS 3
`define CANSF_BIT_BUS_OFF 2
`define CANSF_BIT_OVERRUN 1
`define CANSF_BIT_RX_FULL 0
// ==========================================================
// tx flag and tx control fields
`define CANSF_TXF_EMPTY_LSB 0
`define CANSF_TXF_ABORT_ACK_LSB 4
`define CANSF_TXC_IRQ_EN_LSB 0
`define CANSF_TXC_ABORT_REQ_LSB 4
// module control fields
`define CANSF_MC_SOFT_RESET 0
`define CANSF_MC_SLEEP_REQ 1
`define CANSF_MC_SLEEP_ACK 4
// ==========================================================
// reset values
`define CANSF_RST_RX_FLAGS 8'h00
`define CANSF_RST_RX_IRQ_EN 8'h00
`define CANSF_RST_TX_EMPTY 3'h7
`define CANSF_RST_TX_ABORT_ACK 3'h0
`define CANSF_RST_TX_CTRL 8'h00
`define CANSF_RST_SOFT_RESET 1'b0
// ==========================================================
// error count thresholds and bus-off recovery
`define CANSF_WARN_LIMIT 9'h060
`define CANSF_PASS_LOW 9'h080
`define CANSF_PASS_HIGH 9'h0ff
`define CANSF_BUS_OFF_SEQS 128
`define CANSF_RECESSIVE_BITS 11
`endif

// ===== rtl/cansf_status_flags.v
// Operation
// - rx status flags readable; writing one clears, writing zero ignored
// - a one-write clears a flag only once its cause is gone
// - each rx flag has an enable; hard and soft reset zero flags
// - bus activity in sleep clears sleep acknowledge, then sets wake flag
// - rx warning set at rx count 96 or more, no passive/bus-off flag
// - tx warning set at tx count 96 or more, no passive/bus-off flag
// - rx passive set at rx count 128 to 255 without bus-off flag
// - tx passive set at tx count 128 to 255 without bus-off flag
// - tx count above 255 sets bus-off flag and enters bus-off state
// - bus-off flag stays until 128 runs of 11 recessive bits seen
// - overrun sets overrun flag; error irq from enabled error flags
// - rx full set when new good message lands in foreground buffer
// - no background-to-foreground swap while rx full is set
// - rx irq from rx full and enable; wake irq from wake and enable
// - soft reset holds rx flags, rx enables and tx flags in reset
// - eight rx enables read/write, reset zero, routed to three irqs
// - abort acks read only, empty flags write-one-clear, reset restores
// - abort ack set on dropped message; cleared with its empty flag
// - empty flag set on send or abort; tx irq with its enable
// - setting an empty flag clears that buffer's abort request
// - soft reset bit takes effect at once, aborting bus activity
// - each tx empty enable gates its buffer's empty interrupt
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "cansf_map.vh"

module cansf_status_flags #(
   parameter CNT_W = 9,
   parameter NUM_TX = 3,
   parameter BUS_OFF_SEQS = `CANSF_BUS_OFF_SEQS
) (
   input wire ref_clk_in,
   input wire sys_rst_in,
   // wishbone classic slave
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_we_in,
   input wire [11:0] wb_adr_in,
   input wire [3:0] wb_sel_in,
   input wire [31:0] wb_dat_in,
   output reg [31:0] wb_dat_out,
   output reg wb_ack_out,
   // protocol engine events
   input wire bus_activity_in,
   input wire [CNT_W-1:0] rx_error_count_in,
   input wire [CNT_W-1:0] tx_error_count_in,
   input wire recessive_run_in,
   input wire overrun_in,
   input wire rx_msg_done_in,
   input wire [NUM_TX-1:0] tx_sent_in,
   input wire [NUM_TX-1:0] tx_aborted_in,
   // outputs to the engine
   output reg rx_swap_out,
   output reg soft_reset_out,
   output reg sleep_acknowledge_out,
   output reg bus_off_state_out,
   output reg [NUM_TX-1:0] abort_request_out,
   output reg [NUM_TX-1:0] tx_pending_out,
   // interrupt requests
   output wire wake_irq_out,
   output wire error_irq_out,
   output wire rx_irq_out,
   output wire tx_irq_out
);

   // ==========================================================
   // bus decode
   function hit;
      input [9:0] idx;
      input [9:0] want;
      begin
         hit = (idx == want);
      end
   endfunction

   // recovery counter; BUS_OFF_SEQS above 256 needs it wider
   localparam SEQ_W = 8;
   // reset values as vectors so each bit is picked by index
   // limitation: tx vectors cover three buffers only
   localparam [7:0] RST_RX_FLAGS = `CANSF_RST_RX_FLAGS;
   localparam [2:0] RST_TX_EMPTY = `CANSF_RST_TX_EMPTY;
   localparam [2:0] RST_TX_ABORT = `CANSF_RST_TX_ABORT_ACK;

   wire [9:0] idx;
   wire req;
   wire wr;
   wire wr_rx_flags;
   wire wr_rx_en;
   wire wr_tx_flags;
   wire wr_tx_ctrl;
   wire wr_mod_ctrl;

   assign idx = wb_adr_in[11:2];
   // access takes effect on the edge that raises ack
   assign req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   assign wr = req & wb_we_in & wb_sel_in[0];
   assign wr_rx_flags = wr & hit(idx, `CANSF_IDX_RX_FLAGS);
   assign wr_rx_en = wr & hit(idx, `CANSF_IDX_RX_IRQ_EN);
   assign wr_tx_flags = wr & hit(idx, `CANSF_IDX_TX_FLAGS);
   assign wr_tx_ctrl = wr & hit(idx, `CANSF_IDX_TX_CTRL);
   assign wr_mod_ctrl = wr & hit(idx, `CANSF_IDX_MODULE_CTRL);

   // ==========================================================
   // state
   reg [7:0] rx_flags;
   reg [7:0] rx_irq_enable;
   reg [NUM_TX-1:0] tx_buffer_empty;
   reg [NUM_TX-1:0] abort_acknowledge;
   reg [NUM_TX-1:0] tx_empty_irq_enable;
   reg sleep_request;
   reg wake_pending;
   reg bg_valid;
   reg [SEQ_W-1:0] seq_count;

   wire clr_soft;
   assign clr_soft = sys_rst_in | soft_reset_out;

   // ==========================================================
   // set causes and still-valid conditions per rx flag
   wire rx_warn_lvl;
   wire tx_warn_lvl;
   wire rx_pass_lvl;
   wire tx_pass_lvl;
   wire tx_over_lvl;
   wire no_err_flags;
   wire swap_now;
   wire lost_msg;
   reg [7:0] set_vec;
   reg [7:0] hold_vec;

   assign rx_warn_lvl = rx_error_count_in >= `CANSF_WARN_LIMIT;
   assign tx_warn_lvl = tx_error_count_in >= `CANSF_WARN_LIMIT;
   assign rx_pass_lvl = (rx_error_count_in >= `CANSF_PASS_LOW) &
      (rx_error_count_in <= `CANSF_PASS_HIGH);
   assign tx_pass_lvl = (tx_error_count_in >= `CANSF_PASS_LOW) &
      (tx_error_count_in <= `CANSF_PASS_HIGH);
   assign tx_over_lvl = tx_error_count_in > `CANSF_PASS_HIGH;
   assign no_err_flags = ~rx_flags[`CANSF_BIT_RX_PASS] &
      ~rx_flags[`CANSF_BIT_TX_PASS] & ~rx_flags[`CANSF_BIT_BUS_OFF];

   // foreground swap only while rx full is clear
   assign swap_now = (rx_msg_done_in | bg_valid) &
      ~rx_flags[`CANSF_BIT_RX_FULL] & ~soft_reset_out;
   // a third message with both buffers busy is lost
   assign lost_msg = rx_msg_done_in & bg_valid &
      rx_flags[`CANSF_BIT_RX_FULL];

   always @* begin
      set_vec = 8'h00;
      hold_vec = 8'h00;
      set_vec[`CANSF_BIT_WAKE] = wake_pending;
      set_vec[`CANSF_BIT_RX_WARN] = rx_warn_lvl & no_err_flags;
      set_vec[`CANSF_BIT_TX_WARN] = tx_warn_lvl & no_err_flags;
      set_vec[`CANSF_BIT_RX_PASS] = rx_pass_lvl &
         ~rx_flags[`CANSF_BIT_BUS_OFF];
      set_vec[`CANSF_BIT_TX_PASS] = tx_pass_lvl &
         ~rx_flags[`CANSF_BIT_BUS_OFF];
      set_vec[`CANSF_BIT_BUS_OFF] = tx_over_lvl;
      set_vec[`CANSF_BIT_OVERRUN] = overrun_in | lost_msg;
      set_vec[`CANSF_BIT_RX_FULL] = swap_now;
      // a cause still present blocks the clear
      hold_vec[`CANSF_BIT_RX_WARN] = rx_warn_lvl;
      hold_vec[`CANSF_BIT_TX_WARN] = tx_warn_lvl;
      hold_vec[`CANSF_BIT_RX_PASS] = rx_pass_lvl;
      hold_vec[`CANSF_BIT_TX_PASS] = tx_pass_lvl;
      hold_vec[`CANSF_BIT_BUS_OFF] = bus_off_state_out;
   end

   // ==========================================================
   // rx status flags
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_rx_flag
         wire clr_req;
         assign clr_req = wr_rx_flags & wb_dat_in[gi] & ~hold_vec[gi];
         always @(posedge ref_clk_in) begin
            if (clr_soft) begin
               rx_flags[gi] <= RST_RX_FLAGS[gi];
            end else if (set_vec[gi]) begin
               rx_flags[gi] <= 1'b1;
            end else if (clr_req) begin
               rx_flags[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // ==========================================================
   // rx interrupt enables
   always @(posedge ref_clk_in) begin
      if (clr_soft) begin
         rx_irq_enable <= `CANSF_RST_RX_IRQ_EN;
      end else if (wr_rx_en) begin
         rx_irq_enable <= wb_dat_in[7:0];
      end
   end

   // ==========================================================
   // receive buffer hand-off
   always @(posedge ref_clk_in) begin
      if (clr_soft) begin
         bg_valid <= 1'b0;
         rx_swap_out <= 1'b0;
      end else begin
         rx_swap_out <= swap_now;
         if (swap_now) begin
            bg_valid <= 1'b0;
         end else if (rx_msg_done_in) begin
            bg_valid <= 1'b1;
         end
      end
   end

   // ==========================================================
   // bus-off state and recovery counting
   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         bus_off_state_out <= 1'b0;
         seq_count <= {SEQ_W{1'b0}};
      end else if (tx_over_lvl) begin
         bus_off_state_out <= 1'b1;
         seq_count <= {SEQ_W{1'b0}};
      end else if (bus_off_state_out & recessive_run_in) begin
         // counting survives soft reset, as the counters do
         if (seq_count == BUS_OFF_SEQS - 1) begin
            bus_off_state_out <= 1'b0;
            seq_count <= {SEQ_W{1'b0}};
         end else begin
            seq_count <= seq_count + 1'b1;
         end
      end
   end

   // ==========================================================
   // module control: soft reset and sleep
   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         soft_reset_out <= `CANSF_RST_SOFT_RESET;
         sleep_request <= 1'b0;
         sleep_acknowledge_out <= 1'b0;
         wake_pending <= 1'b0;
      end else begin
         wake_pending <= 1'b0;
         if (wr_mod_ctrl) begin
            soft_reset_out <= wb_dat_in[`CANSF_MC_SOFT_RESET];
         end
         if (soft_reset_out) begin
            sleep_request <= 1'b0;
            sleep_acknowledge_out <= 1'b0;
         end else if (sleep_acknowledge_out & bus_activity_in) begin
            // ack drops first, wake flag follows one cycle later
            sleep_acknowledge_out <= 1'b0;
            sleep_request <= 1'b0;
            wake_pending <= 1'b1;
         end else begin
            if (wr_mod_ctrl) begin
               sleep_request <= wb_dat_in[`CANSF_MC_SLEEP_REQ];
            end
            sleep_acknowledge_out <= sleep_request;
         end
      end
   end

   // ==========================================================
   // transmit buffer flags and control
   generate
      for (gi = 0; gi < NUM_TX; gi = gi + 1) begin : g_tx
         wire set_empty;
         wire clr_empty;
         assign set_empty = tx_sent_in[gi] | tx_aborted_in[gi];
         assign clr_empty = wr_tx_flags &
            wb_dat_in[`CANSF_TXF_EMPTY_LSB + gi];
         always @(posedge ref_clk_in) begin
            if (clr_soft) begin
               tx_buffer_empty[gi] <= RST_TX_EMPTY[gi];
               abort_acknowledge[gi] <= RST_TX_ABORT[gi];
               abort_request_out[gi] <= 1'b0;
               tx_empty_irq_enable[gi] <= 1'b0;
               tx_pending_out[gi] <= ~RST_TX_EMPTY[gi];
            end else begin
               if (set_empty) begin
                  tx_buffer_empty[gi] <= 1'b1;
                  tx_pending_out[gi] <= 1'b0;
               end else if (clr_empty) begin
                  tx_buffer_empty[gi] <= 1'b0;
                  tx_pending_out[gi] <= 1'b1;
               end
               if (tx_aborted_in[gi]) begin
                  abort_acknowledge[gi] <= 1'b1;
               end else if (clr_empty) begin
                  abort_acknowledge[gi] <= 1'b0;
               end
               // cpu may only set a request; hardware clears it
               if (set_empty) begin
                  abort_request_out[gi] <= 1'b0;
               end else if (wr_tx_ctrl &
                  wb_dat_in[`CANSF_TXC_ABORT_REQ_LSB + gi]) begin
                  abort_request_out[gi] <= 1'b1;
               end
               if (wr_tx_ctrl) begin
                  tx_empty_irq_enable[gi] <=
                     wb_dat_in[`CANSF_TXC_IRQ_EN_LSB + gi];
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // interrupt request levels
   wire [7:0] rx_act;
   assign rx_act = rx_flags & rx_irq_enable;
   assign wake_irq_out = rx_act[`CANSF_BIT_WAKE];
   assign rx_irq_out = rx_act[`CANSF_BIT_RX_FULL];
   assign error_irq_out = |rx_act[6:1];
   assign tx_irq_out =
      |(tx_buffer_empty & tx_empty_irq_enable);

   // ==========================================================
   // read mux and ack
   reg [31:0] next_rd;
   always @* begin
      next_rd = 32'h0000_0000;
      case (idx)
         `CANSF_IDX_MODULE_CTRL: begin
            next_rd[`CANSF_MC_SOFT_RESET] = soft_reset_out;
            next_rd[`CANSF_MC_SLEEP_REQ] = sleep_request;
            next_rd[`CANSF_MC_SLEEP_ACK] = sleep_acknowledge_out;
         end
         `CANSF_IDX_RX_FLAGS: begin
            next_rd[7:0] = rx_flags;
         end
         `CANSF_IDX_RX_IRQ_EN: begin
            next_rd[7:0] = rx_irq_enable;
         end
         `CANSF_IDX_TX_FLAGS: begin
            next_rd[`CANSF_TXF_EMPTY_LSB +: NUM_TX] = tx_buffer_empty;
            next_rd[`CANSF_TXF_ABORT_ACK_LSB +: NUM_TX] = abort_acknowledge;
         end
         `CANSF_IDX_TX_CTRL: begin
            next_rd[`CANSF_TXC_IRQ_EN_LSB +: NUM_TX] = tx_empty_irq_enable;
            next_rd[`CANSF_TXC_ABORT_REQ_LSB +: NUM_TX] = abort_request_out;
         end
         `CANSF_IDX_RX_ERR_CNT: begin
            next_rd[CNT_W-1:0] = rx_error_count_in;
         end
         `CANSF_IDX_TX_ERR_CNT: begin
            next_rd[CNT_W-1:0] = tx_error_count_in;
         end
         default: begin
            next_rd = 32'h0000_0000;
         end
      endcase
   end

   always @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end else begin
         // no wait states: ack always one cycle after the take
         wb_ack_out <= req;
         if (req & ~wb_we_in) begin
            wb_dat_out <= next_rd;
         end
      end
   end

endmodule // cansf_status_flags

// ===== verif/cansf_eng_model.sv
`timescale 1ns/1ps
// ==========
// protocol engine stand-in: finishes a pending buffer after a delay
module cansf_eng #(
   parameter DLY = 20
) (
   input wire clk_in,
   input wire rst_in,
   input wire [2:0] pend_in,
   input wire [2:0] abrq_in,
   output reg [2:0] sent_out = 3'h0,
   output reg [2:0] abort_out = 3'h0
);
   integer cnt [0:2];
   integer k;
   always @(posedge clk_in) begin
      for (k = 0; k < 3; k = k + 1) begin
         sent_out[k] <= 1'b0;
         abort_out[k] <= 1'b0;
         // dropped pending, as on soft reset, abandons the buffer
         if (rst_in || !pend_in[k] || sent_out[k] ||
            abort_out[k]) begin
            cnt[k] <= 0;
         end else if (cnt[k] == DLY) begin
            cnt[k] <= 0;
            if (abrq_in[k]) abort_out[k] <= 1'b1;
            else sent_out[k] <= 1'b1;
         end else begin
            cnt[k] <= cnt[k] + 1;
         end
      end
   end
endmodule // cansf_eng

// ===== verif/cansf_status_flags_asserts.sv
`timescale 1ns/1ps
// ==========
// port-level checks
module cansf_sva #(
   parameter CNT_W = 9,
   parameter NUM_TX = 3
) (
   input wire ref_clk_in,
   input wire sys_rst_in,
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_ack_out,
   input wire bus_activity_in,
   input wire [CNT_W-1:0] tx_error_count_in,
   input wire recessive_run_in,
   input wire [NUM_TX-1:0] tx_sent_in,
   input wire [NUM_TX-1:0] tx_aborted_in,
   input wire rx_swap_out,
   input wire soft_reset_out,
   input wire sleep_acknowledge_out,
   input wire bus_off_state_out,
   input wire [NUM_TX-1:0] abort_request_out,
   input wire [NUM_TX-1:0] tx_pending_out,
   input wire wake_irq_out,
   input wire error_irq_out,
   input wire rx_irq_out,
   input wire tx_irq_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   wire [NUM_TX-1:0] done = tx_sent_in | tx_aborted_in;
   wire any_irq = wake_irq_out | error_irq_out | rx_irq_out | tx_irq_out;
   sequence s_req;
      wb_cyc_in && wb_stb_in && !wb_ack_out;
   endsequence
   sequence s_soft_held;
      soft_reset_out ##1 soft_reset_out;
   endsequence
   sequence s_wake_hit;
      sleep_acknowledge_out && bus_activity_in;
   endsequence
   a_ack_one: assert property (s_req |=> wb_ack_out ##1 !wb_ack_out)
      else $error("bus ack is not a single pulse");
   a_soft_quiet: assert property (s_soft_held |-> !any_irq)
      else $error("irq raised while soft reset held");
   a_wake_ack: assert property (s_wake_hit |=> !sleep_acknowledge_out)
      else $error("sleep ack kept after bus activity");
   a_bus_off_set: assert property (
      tx_error_count_in > 9'h0ff |=> bus_off_state_out)
      else $error("bus-off not entered");
   a_bus_off_hold: assert property (
      bus_off_state_out && !recessive_run_in |=> bus_off_state_out)
      else $error("bus-off left without recessive run");
   a_tx_done: assert property (done != 0 |=>
      (tx_pending_out & $past(done)) == 0)
      else $error("buffer still pending after completion");
   a_abrq_clr: assert property (done != 0 |=>
      (abort_request_out & $past(done)) == 0)
      else $error("abort request kept after completion");
   a_tx_irq_src: assert property (tx_irq_out |-> ~tx_pending_out != 0)
      else $error("tx irq without an empty buffer");
   a_swap_free: assert property (rx_swap_out |-> !$past(rx_irq_out))
      else $error("swap while receive buffer full");
endmodule // cansf_sva

bind cansf_status_flags cansf_sva #(.CNT_W(CNT_W), .NUM_TX(NUM_TX))
   i_cansf_sva (
   .ref_clk_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out,
   .bus_activity_in, .tx_error_count_in, .recessive_run_in, .tx_sent_in,
   .tx_aborted_in, .rx_swap_out, .soft_reset_out, .sleep_acknowledge_out,
   .bus_off_state_out, .abort_request_out, .tx_pending_out, .wake_irq_out,
   .error_irq_out, .rx_irq_out, .tx_irq_out);

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
   reg ref_clk_in = 1'b0;
   reg sys_rst_in = 1'b1;
   reg wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
   reg [11:0] wb_adr_in = 12'h000;
   reg [3:0] wb_sel_in = 4'hf;
   reg [31:0] wb_dat_in = 32'h0000_0000;
   reg bus_activity_in = 1'b0, recessive_run_in = 1'b0;
   reg overrun_in = 1'b0, rx_msg_done_in = 1'b0;
   reg [8:0] rx_error_count_in = 9'h000, tx_error_count_in = 9'h000;
   wire [31:0] wb_dat_out;
   wire wb_ack_out, rx_swap_out, soft_reset_out, sleep_acknowledge_out;
   wire bus_off_state_out, wake_irq_out, error_irq_out, rx_irq_out, tx_irq_out;
   wire [2:0] abort_request_out, tx_pending_out, tx_sent_in, tx_aborted_in;
   integer err_total = 0, num_checks = 0, nswap = 0, i;
   integer seed = 32'h30b4_3b7b;
   reg [31:0] expq [$];
   reg [7:0] r;
   always #12.5 ref_clk_in = ~ref_clk_in;
   cansf_status_flags #(.BUS_OFF_SEQS(4)) i_cansf_status_flags (
      .ref_clk_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
      .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .bus_activity_in,
      .rx_error_count_in, .tx_error_count_in, .recessive_run_in, .overrun_in,
      .rx_msg_done_in, .tx_sent_in, .tx_aborted_in, .rx_swap_out,
      .soft_reset_out, .sleep_acknowledge_out, .bus_off_state_out,
      .abort_request_out, .tx_pending_out, .wake_irq_out, .error_irq_out,
      .rx_irq_out, .tx_irq_out);
   cansf_eng i_cansf_eng (.clk_in(ref_clk_in), .rst_in(sys_rst_in),
      .pend_in(tx_pending_out), .abrq_in(abort_request_out),
      .sent_out(tx_sent_in), .abort_out(tx_aborted_in));
   // ==========
   // helpers
   task chk(input string nm, input [31:0] e, input [31:0] g);
      num_checks = num_checks + 1;
      if (g !== e) begin
         err_total = err_total + 1;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge ref_clk_in);
   endtask
   // waits for ack, never assumes its latency
   task bus(input w, input [9:0] x, input [7:0] d);
      integer n;
      n = 0;
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= w;
      wb_adr_in <= {x, 2'b00};
      wb_dat_in <= {24'h00_0000, d};
      do begin
         @(posedge ref_clk_in);
         n = n + 1;
      end while (wb_ack_out !== 1'b1 && n < 20);
      if (n >= 20) chk("ack", 8'h01, 8'h00);
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      @(posedge ref_clk_in);
   endtask
   task rd(input [9:0] x, input [7:0] e);
      expq.push_back({24'h00_0000, e});
      bus(1'b0, x, 8'h00);
   endtask
   task ev(input [3:0] m);
      {bus_activity_in, recessive_run_in, overrun_in, rx_msg_done_in} <= m;
      @(posedge ref_clk_in);
      {bus_activity_in, recessive_run_in, overrun_in, rx_msg_done_in} <= 4'h0;
      @(posedge ref_clk_in);
   endtask
   task tdone(input string s);
      $display("test %s done", s);
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge ref_clk_in) begin
      if (rx_swap_out === 1'b1) nswap = nswap + 1;
      if (wb_ack_out === 1'b1 && wb_we_in === 1'b0) begin
         chk("read data", expq[0], wb_dat_out);
         expq.pop_front();
      end
   end
   initial begin
      repeat (8000) @(posedge ref_clk_in);
      err_total = err_total + 1;
      finish_test;
   end
   // ==========
   // scenarios
   initial begin
      tick(10);
      sys_rst_in <= 1'b0;
      tick(1);
      rd(10'h104, 8'h00);
      rd(10'h105, 8'h00);
      rd(10'h106, 8'h07);
      rd(10'h107, 8'h00);
      rd(10'h1ff, 8'h00);
      for (i = 0; i < 4; i = i + 1) begin
         r = 8'($random(seed));
         bus(1'b1, 10'h105, r);
         rd(10'h105, r);
      end
      wb_sel_in <= 4'he;
      bus(1'b1, 10'h105, ~r);
      wb_sel_in <= 4'hf;
      rd(10'h105, r);
      tdone("registers");
      bus(1'b1, 10'h105, 8'hff);
      rx_error_count_in <= 9'h060;
      tick(2);
      rd(10'h104, 8'h40);
      bus(1'b1, 10'h104, 8'h40);
      rd(10'h104, 8'h40);
      chk("error irq", 8'h01, error_irq_out);
      rx_error_count_in <= 9'h000;
      bus(1'b1, 10'h104, 8'h00);
      rd(10'h104, 8'h40);
      bus(1'b1, 10'h104, 8'h40);
      rd(10'h104, 8'h00);
      // staggered so rx warning meets an already set passive flag
      tx_error_count_in <= 9'h064;
      tick(2);
      tx_error_count_in <= 9'h082;
      tick(2);
      rx_error_count_in <= 9'h0c8;
      tick(2);
      rd(10'h104, 8'h38);
      rd(10'h10e, 8'hc8);
      rd(10'h10f, 8'h82);
      tx_error_count_in <= 9'h12c;
      tick(2);
      rd(10'h104, 8'h3c);
      tx_error_count_in <= 9'h000;
      rx_error_count_in <= 9'h000;
      bus(1'b1, 10'h104, 8'hff);
      rd(10'h104, 8'h04);
      repeat (3) ev(4'h4);
      chk("bus off", 8'h01, bus_off_state_out);
      ev(4'h4);
      chk("bus off", 8'h00, bus_off_state_out);
      bus(1'b1, 10'h104, 8'h04);
      rd(10'h104, 8'h00);
      ev(4'h2);
      rd(10'h104, 8'h02);
      bus(1'b1, 10'h104, 8'h02);
      chk("error irq", 8'h00, error_irq_out);
      tdone("error flags");
      ev(4'h1);
      rd(10'h104, 8'h01);
      chk("rx irq", 8'h01, rx_irq_out);
      ev(4'h1);
      chk("swaps", 8'h01, nswap);
      // third message with both buffers busy is lost
      ev(4'h1);
      rd(10'h104, 8'h03);
      bus(1'b1, 10'h104, 8'h01);
      tick(2);
      chk("swaps", 8'h02, nswap);
      rd(10'h104, 8'h03);
      bus(1'b1, 10'h104, 8'h03);
      chk("rx irq", 8'h00, rx_irq_out);
      chk("error irq", 8'h00, error_irq_out);
      tdone("receive");
      bus(1'b1, 10'h100, 8'h02);
      tick(2);
      rd(10'h100, 8'h12);
      ev(4'h8);
      bus(1'b1, 10'h100, 8'h00);
      rd(10'h104, 8'h80);
      chk("wake irq", 8'h01, wake_irq_out);
      bus(1'b1, 10'h105, 8'h7f);
      chk("wake irq", 8'h00, wake_irq_out);
      bus(1'b1, 10'h104, 8'h80);
      rd(10'h104, 8'h00);
      tdone("wake");
      bus(1'b1, 10'h107, 8'h07);
      chk("tx irq", 8'h01, tx_irq_out);
      bus(1'b1, 10'h106, 8'h01);
      bus(1'b1, 10'h106, 8'h02);
      bus(1'b1, 10'h107, 8'h27);
      bus(1'b1, 10'h106, 8'h70);
      rd(10'h106, 8'h04);
      tick(30);
      rd(10'h106, 8'h27);
      rd(10'h107, 8'h07);
      bus(1'b1, 10'h106, 8'h02);
      rd(10'h106, 8'h05);
      bus(1'b1, 10'h107, 8'h00);
      chk("tx irq", 8'h00, tx_irq_out);
      tick(30);
      tdone("transmit");
      bus(1'b1, 10'h105, 8'hff);
      ev(4'h2);
      bus(1'b1, 10'h100, 8'h01);
      chk("soft reset", 8'h01, soft_reset_out);
      rd(10'h104, 8'h00);
      bus(1'b1, 10'h105, 8'hff);
      rd(10'h105, 8'h00);
      rd(10'h106, 8'h07);
      bus(1'b1, 10'h100, 8'h00);
      rd(10'h104, 8'h00);
      tdone("soft reset");
      finish_test;
   end
endmodule // tb
